// ### core/tx_stats_pkg.sv
// Purpose: Shared constants for the per-port transmit statistics block.
// Assumes: One port per instance; status words arrive from the port's MAC.
// Notes:   Counter slots, field widths, size-bin limits and reset values.
package tx_stats_pkg;

	// Counter and field widths
	localparam int CNT_W   = 32;                  // Event counters
	localparam int BYTE_W  = 64;                  // Good byte counter
	localparam int LEN_W   = 14;                  // Frame length, jumbo fits
	localparam int COLL_W  = 5;                   // Collisions seen by one frame
	localparam int QUEUE_W = 3;                   // Class-of-service queue number

	// Fixed counter population of one port
	localparam int COUNTERS_PER_PORT = 43;
	localparam int RX_ONLY_COUNT     = 19;
	localparam int TX_ONLY_COUNT     = 18;
	localparam int SHARED_COUNT      = 6;
	localparam int NUM_QUEUES        = 6;

	// Destination kind carried in a transmit status word
	localparam logic [1:0] DEST_UCAST = 2'h0;
	localparam logic [1:0] DEST_MCAST = 2'h1;
	localparam logic [1:0] DEST_BCAST = 2'h2;

	// Size-bin boundaries in bytes, preamble excluded, check sequence included
	localparam logic [LEN_W-1:0] BIN_MIN_LEN      = 14'h0040;
	localparam logic [LEN_W-1:0] BIN_SMALL_LO     = 14'h0041;
	localparam logic [LEN_W-1:0] BIN_SMALL_HI     = 14'h007F;
	localparam logic [LEN_W-1:0] BIN_LOWMID_LO    = 14'h0080;
	localparam logic [LEN_W-1:0] BIN_LOWMID_HI    = 14'h00FF;
	localparam logic [LEN_W-1:0] BIN_MID_LO       = 14'h0100;
	localparam logic [LEN_W-1:0] BIN_MID_HI       = 14'h01FF;
	localparam logic [LEN_W-1:0] BIN_UPMID_LO     = 14'h0200;
	localparam logic [LEN_W-1:0] BIN_UPMID_HI     = 14'h03FF;
	localparam logic [LEN_W-1:0] BIN_LARGE_LO     = 14'h0400;
	localparam logic [LEN_W-1:0] STD_MAX_FRAME_LEN = 14'h05F2;

	// Slots of the 32-bit counter bank
	localparam int IDX_LOST      = 0;
	localparam int IDX_BCAST     = 1;
	localparam int IDX_MCAST     = 2;
	localparam int IDX_COLL      = 3;
	localparam int IDX_UCAST     = 4;
	localparam int IDX_ONE_COLL  = 5;
	localparam int IDX_MULTI     = 6;
	localparam int IDX_DEFER     = 7;
	localparam int IDX_LATE      = 8;
	localparam int IDX_EXCESS    = 9;
	localparam int IDX_PAUSE     = 10;
	localparam int IDX_DISCARD   = 11;
	localparam int IDX_QUEUE0    = 12;
	localparam int IDX_BIN0      = 18;
	localparam int NUM_CNT       = 24;

	// Reset and step values
	localparam logic [CNT_W-1:0]  CNT_RESET  = 32'h0000_0000;
	localparam logic [CNT_W-1:0]  CNT_STEP   = 32'h0000_0001;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 64'h0000_0000_0000_0000;

endpackage : tx_stats_pkg

// ### core/count_if.sv
// Purpose: Carrier between the statistics core and one wrapping counter.
// Assumes: One clock; the counter owns the stored value.
// Notes:   User side drives the increment request and step.
`timescale 1ns/10ps
`default_nettype none
interface count_if #(parameter int W = 32) ();
	logic         inc;          // Add step this cycle
	logic [W-1:0] add;          // Step size
	logic [W-1:0] value;        // Current count
	modport owner (input inc, input add, output value);
	modport user  (output inc, output add, input value);
endinterface : count_if
`default_nettype wire

// ### core/wrap_counter.sv
// Purpose: One statistics counter that adds a step and wraps at its width.
// Assumes: Synchronous active-low reset.
// Notes:   Overflow wraps silently; software reads often enough to see it.
`timescale 1ns/10ps
`default_nettype none
module wrap_counter
	import tx_stats_pkg::*;
#(
	parameter int W = 32
)
(
	input  wire logic mclk,
	input  wire logic nrst,
	count_if.owner    cnt
);

	// Width check, the step adds modulo two to the W
	initial
	begin
		if (W < 1 || W > 64)
			$error("wrap_counter width out of range");
	end

	logic [W-1:0] value_reg;    // Stored count

	// Count update, wraps to zero naturally
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			value_reg <= '0;
		else if (cnt.inc)
			value_reg <= value_reg + cnt.add;    // see R23
	end

	assign cnt.value = value_reg;

endmodule : wrap_counter
`default_nettype wire

// ### core/port_tx_statistics_counters.sv
// Purpose: Transmit and size-bin statistics of one switch port.
// Assumes: Status words are one-cycle pulses synchronous to mclk.
// Notes:   Decoding is registered once; counters move two edges after a word.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R01: Lost frames and uncounted internal errors count
// R02: Good frame bytes accumulate into 64 bits
// R03: Good broadcast frames counted only
// R04: Good multicast frames counted only
// R05: Every transmit collision adds one
// R06: Good unicast frames counted
// R07: Success after exactly one collision counts
// R08: Success after two or more collisions
// R09: Deferred first attempt, half duplex only
// R10: Collisions past 512 bit-times counted
// R11: Every pause event adds one
// R12: Output queue space drops counted separately
// R13: Six queue counters under quality of service
// R14: Exactly 64-byte frames, errors included
// R15: Frames of 65 to 127 bytes
// R16: Frames of 128 to 255 bytes
// R17: Frames of 256 to 511 bytes
// R18: Frames of 512 to 1023 bytes
// R19: Frames of 1024 to maximum size
// R20: Port holds 43 counters across groups
// R21: Size bins steered whole to one direction
// R22: Receive words feed receive, transmit words transmit
// R23: One step per word, wrap at width
module port_tx_statistics_counters
	import tx_stats_pkg::*;
#(
	parameter logic [LEN_W-1:0] MAX_FRAME_LEN = STD_MAX_FRAME_LEN
)
(
	input  wire logic                      mclk,
	input  wire logic                      nrst,
	// Transmit status word from the MAC
	input  wire logic                      tx_status_valid,
	input  wire logic                      tx_final,
	input  wire logic                      tx_good,
	input  wire logic [LEN_W-1:0]          tx_frame_len,
	input  wire logic [1:0]                tx_dest_kind,
	input  wire logic                      tx_collision,
	input  wire logic                      tx_late_collision,
	input  wire logic [COLL_W-1:0]         tx_frame_collisions,
	input  wire logic                      tx_excess_collision,
	input  wire logic                      tx_underflow,
	input  wire logic                      tx_internal_error,
	input  wire logic                      tx_deferred,
	input  wire logic                      tx_pause_event,
	input  wire logic [QUEUE_W-1:0]        tx_queue,
	// Receive status word, used only by the size bins
	input  wire logic                      rx_status_valid,
	input  wire logic [LEN_W-1:0]          rx_frame_len,
	// Forwarding process and port configuration
	input  wire logic                      output_queue_drop,
	input  wire logic                      half_duplex,
	input  wire logic                      qos_enable,
	input  wire logic                      bins_count_tx,
	// Counter values
	output logic [CNT_W-1:0]               tx_lost_frame_count,
	output logic [BYTE_W-1:0]              tx_good_byte_count,
	output logic [CNT_W-1:0]               tx_bcast_frame_count,
	output logic [CNT_W-1:0]               tx_mcast_frame_count,
	output logic [CNT_W-1:0]               tx_collision_event_count,
	output logic [CNT_W-1:0]               tx_ucast_frame_count,
	output logic [CNT_W-1:0]               tx_one_collision_frame_count,
	output logic [CNT_W-1:0]               tx_multi_collision_frame_count,
	output logic [CNT_W-1:0]               tx_deferred_frame_count,
	output logic [CNT_W-1:0]               tx_late_collision_count,
	output logic [CNT_W-1:0]               tx_excess_collision_count,
	output logic [CNT_W-1:0]               tx_pause_event_count,
	output logic [CNT_W-1:0]               output_queue_discard_count,
	output logic [NUM_QUEUES-1:0][CNT_W-1:0] queue_good_frame_count,
	output logic [CNT_W-1:0]               size_bin_min_count,
	output logic [CNT_W-1:0]               size_bin_small_count,
	output logic [CNT_W-1:0]               size_bin_lowmid_count,
	output logic [CNT_W-1:0]               size_bin_mid_count,
	output logic [CNT_W-1:0]               size_bin_upmid_count,
	output logic [CNT_W-1:0]               size_bin_large_count
);

	// Elaboration checks on the maximum frame setting and the population
	initial
	begin
		if (MAX_FRAME_LEN < BIN_LARGE_LO)
			$error("MAX_FRAME_LEN below the largest bin's lower edge");
		if (RX_ONLY_COUNT + TX_ONLY_COUNT + SHARED_COUNT != COUNTERS_PER_PORT)
			$error("counter groups do not add up to the port total");    // see R20
		if (NUM_CNT != IDX_BIN0 + SHARED_COUNT)
			$error("counter bank slots inconsistent");
	end

	// Size-bin decode, shared by both directions
	function automatic logic [SHARED_COUNT-1:0] size_bin
	(
		input logic [LEN_W-1:0] len
	);
		logic [SHARED_COUNT-1:0] hit;    // One-hot bin, zero when outside all
		hit    = '0;
		hit[0] = (len == BIN_MIN_LEN);                                 // see R14
		hit[1] = (len >= BIN_SMALL_LO)  && (len <= BIN_SMALL_HI);      // see R15
		hit[2] = (len >= BIN_LOWMID_LO) && (len <= BIN_LOWMID_HI);     // see R16
		hit[3] = (len >= BIN_MID_LO)    && (len <= BIN_MID_HI);        // see R17
		hit[4] = (len >= BIN_UPMID_LO)  && (len <= BIN_UPMID_HI);      // see R18
		hit[5] = (len >= BIN_LARGE_LO)  && (len <= MAX_FRAME_LEN);     // see R19
		return hit;
	endfunction : size_bin

	// Word qualifiers
	logic tx_word;               // Transmit status word present
	logic tx_done;               // Word closes a frame
	logic tx_ok;                 // Frame closed good
	logic [NUM_CNT-1:0] inc_next;      // Increment requests for the bank
	logic [NUM_CNT-1:0] inc_reg;       // Registered requests
	logic               byte_inc_next; // Byte counter request
	logic               byte_inc_reg;
	logic [LEN_W-1:0]   byte_len_reg;  // Length field of the previous cycle's word, good or not
	logic [SHARED_COUNT-1:0] bin_hit;  // Bin hit of the selected direction
	logic [CNT_W-1:0]   count_value [NUM_CNT];  // Bank values
	logic [NUM_QUEUES-1:0] queue_hit;   // Queue of a good frame

	assign tx_word = tx_status_valid;                   // see R22
	assign tx_done = tx_word && tx_final;
	assign tx_ok   = tx_done && tx_good;

	// Size-bin source, steered as a group; the other direction is ignored
	always_comb
	begin
		bin_hit = '0;
		if (bins_count_tx)
		begin
			// Transmit frames, closing word only so retries are not counted twice
			if (tx_done)
				bin_hit = size_bin(tx_frame_len);             // see R21
		end
		else
		begin
			// Receive frames
			if (rx_status_valid)
				bin_hit = size_bin(rx_frame_len);             // see R21
		end
	end

	// Transmit-only event decode
	always_comb
	begin
		inc_next = '0;
		// Lost to resources, or an internal error no collision counter owns
		inc_next[IDX_LOST] = tx_done && (tx_underflow ||
			(tx_internal_error && !tx_late_collision && !tx_excess_collision)); // see R01
		// Destination classes, good frames only
		inc_next[IDX_BCAST] = tx_ok && (tx_dest_kind == DEST_BCAST);    // see R03
		inc_next[IDX_MCAST] = tx_ok && (tx_dest_kind == DEST_MCAST);    // see R04
		inc_next[IDX_UCAST] = tx_ok && (tx_dest_kind == DEST_UCAST);    // see R06
		// Each collision arrives in a word of its own
		inc_next[IDX_COLL] = tx_word && tx_collision;                   // see R05
		// Success after retries, sorted by how many
		inc_next[IDX_ONE_COLL] = tx_ok && (tx_frame_collisions == 5'h01); // see R07
		inc_next[IDX_MULTI]    = tx_ok && (tx_frame_collisions > 5'h01);  // see R08
		// Deferral means nothing in full duplex
		inc_next[IDX_DEFER] = tx_done && tx_deferred && half_duplex;    // see R09
		// The MAC flags collisions beyond the slot time
		inc_next[IDX_LATE] = tx_word && tx_collision && tx_late_collision; // see R10
		inc_next[IDX_EXCESS] = tx_done && tx_excess_collision;
		inc_next[IDX_PAUSE] = tx_word && tx_pause_event;                // see R11
		// Forwarding drop, independent of any status word
		inc_next[IDX_DISCARD] = output_queue_drop;                      // see R12
	end

	// Per-queue good frames, only with quality of service on
	generate
		for (genvar q = 0; q < NUM_QUEUES; q++)
		begin : g_queue
			assign queue_hit[q] = qos_enable && tx_ok &&
				(tx_queue == QUEUE_W'(q));                                // see R13
		end
	endgenerate

	// Good bytes request
	assign byte_inc_next = tx_ok;        // see R02

	// Register the decoded requests to keep compare logic off the adders
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			inc_reg <= '0;
		else
			inc_reg <= {bin_hit, queue_hit, inc_next[IDX_DISCARD:0]};
	end

	// Register the byte request with its length
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			byte_inc_reg <= 1'b0;
			byte_len_reg <= '0;
		end
		else
		begin
			byte_inc_reg <= byte_inc_next;
			byte_len_reg <= tx_frame_len;
		end
	end

	// Counter bank, one step per word each
	generate
		for (genvar i = 0; i < NUM_CNT; i++)
		begin : g_cnt
			count_if #(.W(CNT_W)) cnt_bus ();
			assign cnt_bus.inc = inc_reg[i];
			assign cnt_bus.add = CNT_STEP;                              // see R23
			wrap_counter #(.W(CNT_W)) u_cnt
			(
				.mclk (mclk),
				.nrst (nrst),
				.cnt  (cnt_bus)
			);
			assign count_value[i] = cnt_bus.value;
		end
	endgenerate

	// Byte counter adds the whole frame length, check sequence included
	count_if #(.W(BYTE_W)) byte_bus ();
	assign byte_bus.inc = byte_inc_reg;
	assign byte_bus.add = {{(BYTE_W-LEN_W){1'b0}}, byte_len_reg};    // see R02
	wrap_counter #(.W(BYTE_W)) u_byte_cnt
	(
		.mclk (mclk),
		.nrst (nrst),
		.cnt  (byte_bus)
	);

	// Counter outputs, each the flop inside its counter
	assign tx_lost_frame_count            = count_value[IDX_LOST];
	assign tx_good_byte_count             = byte_bus.value;
	assign tx_bcast_frame_count           = count_value[IDX_BCAST];
	assign tx_mcast_frame_count           = count_value[IDX_MCAST];
	assign tx_collision_event_count       = count_value[IDX_COLL];
	assign tx_ucast_frame_count           = count_value[IDX_UCAST];
	assign tx_one_collision_frame_count   = count_value[IDX_ONE_COLL];
	assign tx_multi_collision_frame_count = count_value[IDX_MULTI];
	assign tx_deferred_frame_count        = count_value[IDX_DEFER];
	assign tx_late_collision_count        = count_value[IDX_LATE];
	assign tx_excess_collision_count      = count_value[IDX_EXCESS];
	assign tx_pause_event_count           = count_value[IDX_PAUSE];
	assign output_queue_discard_count     = count_value[IDX_DISCARD];

	// Queue counters in queue order
	generate
		for (genvar q = 0; q < NUM_QUEUES; q++)
		begin : g_qout
			assign queue_good_frame_count[q] = count_value[IDX_QUEUE0 + q];
		end
	endgenerate

	// Size bins, smallest first
	assign size_bin_min_count    = count_value[IDX_BIN0];
	assign size_bin_small_count  = count_value[IDX_BIN0 + 1];
	assign size_bin_lowmid_count = count_value[IDX_BIN0 + 2];
	assign size_bin_mid_count    = count_value[IDX_BIN0 + 3];
	assign size_bin_upmid_count  = count_value[IDX_BIN0 + 4];
	assign size_bin_large_count  = count_value[IDX_BIN0 + 5];

endmodule : port_tx_statistics_counters
`default_nettype wire

// ### testbench/mac_status_model.sv
// Purpose: Stand-in for the port MAC that reports transmit status words.
// Assumes: One word a call, launched just after a rising mclk edge.
// Notes:   Released fields are inverted so a stale word never looks valid.
`timescale 1ns/10ps
`default_nettype none
module mac_status_model
	import tx_stats_pkg::*;
(
	input  wire logic                mclk,
	output logic                     tx_status_valid,
	output logic                     tx_final,
	output logic                     tx_good,
	output logic                     tx_collision,
	output logic                     tx_late_collision,
	output logic                     tx_excess_collision,
	output logic                     tx_underflow,
	output logic                     tx_internal_error,
	output logic                     tx_deferred,
	output logic                     tx_pause_event,
	output logic [LEN_W-1:0]         tx_frame_len,
	output logic [1:0]               tx_dest_kind,
	output logic [COLL_W-1:0]        tx_frame_collisions,
	output logic [QUEUE_W-1:0]       tx_queue
);
	// Whole word in one vector, so release is a single inversion
	logic [32:0] f;
	assign {tx_final, tx_good, tx_collision, tx_late_collision, tx_excess_collision,
		tx_underflow, tx_internal_error, tx_deferred, tx_pause_event,
		tx_frame_len, tx_dest_kind, tx_frame_collisions, tx_queue} = f;
	initial
	begin
		tx_status_valid = 1'b0;
		f = '0;
	end
	// Present one status word; it stays until the next call or idle
	task automatic word(input logic [8:0] flg, input logic [LEN_W-1:0] len,
		input logic [1:0] dst, input logic [COLL_W-1:0] nc, input logic [QUEUE_W-1:0] q);
		@(posedge mclk);
		tx_status_valid <= 1'b1;
		f <= {flg, len, dst, nc, q};
	endtask : word
	// Drop the strobe and scramble the fields
	task automatic idle();
		@(posedge mclk);
		tx_status_valid <= 1'b0;
		f <= ~f;
	endtask : idle
endmodule : mac_status_model
`default_nettype wire

// ### testbench/port_tx_statistics_counters_assertions.sv
// Purpose: Timing and value checks on the transmit counter outputs.
// Assumes: Counters move one edge after the edge that registers a word.
// Notes:   Each check compares two samples, so it tolerates back-to-back words.
`timescale 1ns/10ps
`default_nettype none
module port_tx_statistics_counters_assertions
	import tx_stats_pkg::*;
#(
	parameter logic [LEN_W-1:0] MAX_FRAME_LEN = STD_MAX_FRAME_LEN
)
(
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              tx_status_valid,
	input  wire logic              tx_final,
	input  wire logic              tx_good,
	input  wire logic [LEN_W-1:0]  tx_frame_len,
	input  wire logic [1:0]        tx_dest_kind,
	input  wire logic              tx_collision,
	input  wire logic              tx_pause_event,
	input  wire logic              output_queue_drop,
	input  wire logic              half_duplex,
	input  wire logic              bins_count_tx,
	input  wire logic [CNT_W-1:0]  tx_collision_event_count,
	input  wire logic [CNT_W-1:0]  tx_bcast_frame_count,
	input  wire logic [BYTE_W-1:0] tx_good_byte_count,
	input  wire logic [CNT_W-1:0]  tx_deferred_frame_count,
	input  wire logic [CNT_W-1:0]  tx_pause_event_count,
	input  wire logic [CNT_W-1:0]  output_queue_discard_count,
	input  wire logic [CNT_W-1:0]  size_bin_min_count
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic fin;
	assign fin = tx_status_valid && tx_final;
	a_coll_step: assert property (tx_status_valid && tx_collision |->
		##2 tx_collision_event_count == $past(tx_collision_event_count) + CNT_STEP)
		else $error("collision count did not step");
	a_coll_hold: assert property (!(tx_status_valid && tx_collision) |->
		##2 $stable(tx_collision_event_count)) else $error("collision count moved");
	a_bcast_good: assert property (fin && tx_good && tx_dest_kind == DEST_BCAST |->
		##2 tx_bcast_frame_count == $past(tx_bcast_frame_count) + CNT_STEP)
		else $error("broadcast count did not step");
	a_bcast_errored: assert property (fin && !tx_good |->
		##2 $stable(tx_bcast_frame_count)) else $error("errored frame counted");
	a_bytes_add: assert property (fin && tx_good |->
		##2 tx_good_byte_count == $past(tx_good_byte_count) + BYTE_W'($past(tx_frame_len, 2)))
		else $error("byte count wrong");
	a_defer_full: assert property (fin && !half_duplex |->
		##2 $stable(tx_deferred_frame_count)) else $error("deferral in full duplex");
	a_min_bin: assert property (fin && bins_count_tx && tx_frame_len == BIN_MIN_LEN |->
		##2 size_bin_min_count == $past(size_bin_min_count) + CNT_STEP)
		else $error("minimum bin did not step");
	a_pause_step: assert property (tx_status_valid && tx_pause_event |->
		##2 tx_pause_event_count == $past(tx_pause_event_count) + CNT_STEP)
		else $error("pause count did not step");
	a_discard_step: assert property (output_queue_drop |->
		##2 output_queue_discard_count == $past(output_queue_discard_count) + CNT_STEP)
		else $error("discard count did not step");
endmodule : port_tx_statistics_counters_assertions
bind port_tx_statistics_counters port_tx_statistics_counters_assertions
	#(.MAX_FRAME_LEN(MAX_FRAME_LEN)) u_chk (.*);
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the transmit statistics block.
// Assumes: Counters readable one edge after the edge that takes a word.
// Notes:   Expected counts accumulate across scenarios from reset.
`timescale 1ns/10ps
`default_nettype none
module tb
	import tx_stats_pkg::*;
;
	// Status flag bits: final good coll late excess underflow internal defer pause
	localparam logic [8:0] FIN = 9'h100, GOOD = 9'h080, COLL = 9'h040, LATE = 9'h020;
	localparam logic [8:0] EXC = 9'h010, UND = 9'h008, IERR = 9'h004, DFR = 9'h002;
	localparam logic [8:0] PSE = 9'h001;
	logic mclk, nrst, rx_status_valid, output_queue_drop, half_duplex, qos_enable;
	logic bins_count_tx, tx_status_valid, tx_final, tx_good, tx_collision, tx_late_collision;
	logic tx_excess_collision, tx_underflow, tx_internal_error, tx_deferred, tx_pause_event;
	logic [LEN_W-1:0] tx_frame_len, rx_frame_len;
	logic [1:0] tx_dest_kind;
	logic [COLL_W-1:0] tx_frame_collisions;
	logic [QUEUE_W-1:0] tx_queue;
	logic [CNT_W-1:0] tx_lost_frame_count, tx_bcast_frame_count, tx_mcast_frame_count;
	logic [CNT_W-1:0] tx_collision_event_count, tx_ucast_frame_count, tx_late_collision_count;
	logic [CNT_W-1:0] tx_one_collision_frame_count, tx_multi_collision_frame_count;
	logic [CNT_W-1:0] tx_deferred_frame_count, tx_excess_collision_count, tx_pause_event_count;
	logic [CNT_W-1:0] output_queue_discard_count, size_bin_min_count, size_bin_small_count;
	logic [CNT_W-1:0] size_bin_lowmid_count, size_bin_mid_count, size_bin_upmid_count;
	logic [CNT_W-1:0] size_bin_large_count;
	logic [BYTE_W-1:0] tx_good_byte_count;
	logic [NUM_QUEUES-1:0][CNT_W-1:0] queue_good_frame_count;
	int failures = 0;
	int total_checks = 0;
	port_tx_statistics_counters u_port_tx_statistics_counters (.*);
	mac_status_model u_mac_status_model (.*);
	// Free-running 125 MHz clock
	initial mclk = 1'b0;
	always #4 mclk = ~mclk;
	task automatic report_and_stop();
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [BYTE_W-1:0] seen, input logic [BYTE_W-1:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic w(input logic [8:0] flg, input logic [LEN_W-1:0] len, input logic [1:0] dst,
		input logic [COLL_W-1:0] nc, input logic [QUEUE_W-1:0] q);
		u_mac_status_model.word(flg, len, dst, nc, q);
	endtask : w
	// Receive word; held until the next call or settle
	task automatic rx(input logic [LEN_W-1:0] len);
		@(posedge mclk);
		rx_status_valid <= 1'b1;
		rx_frame_len <= len;
	endtask : rx
	// Release all strobes, then wait the fixed two-edge update latency
	task automatic settle();
		u_mac_status_model.idle();
		rx_status_valid <= 1'b0;
		rx_frame_len <= ~rx_frame_len;
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle
	task automatic s_reset();
		chk("lost", tx_lost_frame_count, 64'h0);
		chk("bytes", tx_good_byte_count, 64'h0);
		for (int i = 0; i < NUM_QUEUES; i++)
			chk("queue", queue_good_frame_count[i], 64'h0);
	endtask : s_reset
	// Back-to-back good frames of each kind, then errored ones
	task automatic s_good();
		w(FIN | GOOD, 14'h0040, DEST_BCAST, 5'h00, 3'h0);
		w(FIN | GOOD, 14'h0064, DEST_MCAST, 5'h00, 3'h2);
		w(FIN | GOOD, 14'h05F2, DEST_UCAST, 5'h00, 3'h5);
		w(FIN, 14'h012C, DEST_BCAST, 5'h00, 3'h5);
		w(FIN, 14'h05F3, DEST_MCAST, 5'h00, 3'h5);
		settle();
		chk("bcast", tx_bcast_frame_count, 64'h1);
		chk("mcast", tx_mcast_frame_count, 64'h1);
		chk("ucast", tx_ucast_frame_count, 64'h1);
		chk("bytes", tx_good_byte_count, 64'h696);
		chk("q0", queue_good_frame_count[0], 64'h1);
		chk("q2", queue_good_frame_count[2], 64'h1);
		chk("q5", queue_good_frame_count[5], 64'h1);
		chk("min", size_bin_min_count, 64'h1);
		chk("small", size_bin_small_count, 64'h1);
		chk("mid", size_bin_mid_count, 64'h1);
		chk("large", size_bin_large_count, 64'h1);
	endtask : s_good
	// Attempt words with collisions, then successes after one and three
	task automatic s_coll();
		@(posedge mclk);
		qos_enable <= 1'b0;
		w(COLL, 14'h0000, 2'h3, 5'h00, 3'h1);
		w(COLL | LATE, 14'h0000, 2'h3, 5'h00, 3'h1);
		w(LATE, 14'h0000, 2'h3, 5'h00, 3'h1);
		w(COLL, 14'h0000, 2'h3, 5'h00, 3'h1);
		w(FIN | GOOD, 14'h003F, 2'h3, 5'h01, 3'h1);
		w(FIN | GOOD, 14'h003F, 2'h3, 5'h03, 3'h1);
		settle();
		chk("coll", tx_collision_event_count, 64'h3);
		chk("late", tx_late_collision_count, 64'h1);
		chk("one", tx_one_collision_frame_count, 64'h1);
		chk("multi", tx_multi_collision_frame_count, 64'h1);
		chk("bytes", tx_good_byte_count, 64'h714);
		chk("q1", queue_good_frame_count[1], 64'h0);
	endtask : s_coll
	// Lost, excess, deferral, pause and discard outcomes
	task automatic s_faults();
		@(posedge mclk);
		output_queue_drop <= 1'b1;
		@(posedge mclk);
		output_queue_drop <= 1'b0;
		w(FIN | UND, 14'h003F, 2'h3, 5'h00, 3'h0);
		w(FIN | IERR | LATE, 14'h003F, 2'h3, 5'h00, 3'h0);
		w(FIN | IERR | EXC, 14'h003F, 2'h3, 5'h00, 3'h0);
		w(FIN | IERR, 14'h003F, 2'h3, 5'h00, 3'h0);
		w(FIN | DFR, 14'h003F, 2'h3, 5'h00, 3'h0);
		w(PSE, 14'h0000, 2'h3, 5'h00, 3'h0);
		w(PSE | COLL, 14'h0000, 2'h3, 5'h00, 3'h0);
		settle();
		chk("lost", tx_lost_frame_count, 64'h2);
		chk("excess", tx_excess_collision_count, 64'h1);
		chk("pause", tx_pause_event_count, 64'h2);
		chk("coll", tx_collision_event_count, 64'h4);
		chk("discard", output_queue_discard_count, 64'h1);
		chk("defer", tx_deferred_frame_count, 64'h0);
		@(posedge mclk);
		half_duplex <= 1'b1;
		w(FIN | DFR, 14'h003F, 2'h3, 5'h00, 3'h0);
		settle();
		chk("defer", tx_deferred_frame_count, 64'h1);
	endtask : s_faults
	// Bins steered to receive; transmit frames must not count
	task automatic s_rx_bins();
		@(posedge mclk);
		bins_count_tx <= 1'b0;
		rx(14'h0080);
		rx(14'h00FF);
		rx(14'h0200);
		rx(14'h03FF);
		rx(14'h0040);
		settle();
		w(FIN, 14'h0040, DEST_UCAST, 5'h00, 3'h0);
		settle();
		chk("lowmid", size_bin_lowmid_count, 64'h2);
		chk("upmid", size_bin_upmid_count, 64'h2);
		chk("min", size_bin_min_count, 64'h2);
	endtask : s_rx_bins
	// Watchdog against a stalled run
	initial
	begin
		repeat (5000) @(posedge mclk);
		failures++;
		report_and_stop();
	end
	initial
	begin
		nrst = 1'b0;
		rx_status_valid = 1'b0;
		rx_frame_len = '0;
		output_queue_drop = 1'b0;
		half_duplex = 1'b0;
		qos_enable = 1'b1;
		bins_count_tx = 1'b1;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		#1;
		s_reset();
		s_good();
		s_coll();
		s_faults();
		s_rx_bins();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
